// >>> psg_gen.sv
`timescale 1ns/10ps
`include "psg_map.svh"
module psg_gen #(
  parameter bit HAS_REG = 1'b1,
  parameter bit HAS_PRI = 1'b1
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // Regular data port
  input  wire logic        reg_ready,
  output logic             reg_valid,
  output logic      [7:0]  reg_data,
  output logic             reg_sop,
  output logic             reg_eop,
  output logic             reg_err,
  output logic      [7:0]  reg_chan,
  // Priority data port
  input  wire logic        pri_ready,
  output logic             pri_valid,
  output logic      [7:0]  pri_data,
  output logic             pri_sop,
  output logic             pri_eop,
  output logic             pri_err,
  output logic      [3:0]  pri_chan
);

  // Configuration registers
  logic [8:0]  ctrl, next_ctrl;
  logic [15:0] reg_len, next_reg_len;
  logic [15:0] pri_len, next_pri_len;
  logic [31:0] reg_pkts, next_reg_pkts;
  logic [31:0] pri_pkts, next_pri_pkts;
  logic [31:0] stream_total, next_stream_total;
  logic [7:0]  reg_tag, next_reg_tag;
  logic [3:0]  pri_tag, next_pri_tag;
  logic [15:0] period, next_period;
  logic [1:0]  go, next_go;
  logic        rate_kick, next_rate_kick;
  logic [31:0] next_rdata;

  // Per-port views
  wire  [1:0]        rdy, busy, start_ok, pkt_flags;
  wire  [1:0][15:0]  len_sel;
  wire  [1:0][31:0]  cnt_sel;
  wire  [1:0][7:0]   tag_sel, mem_rd, port_data, port_chan;
  wire  [1:0]        port_valid, port_sop, port_eop, port_err;
  wire               pri_too_long, period_bad, rate_busy, user_wr, use_arr;
  wire  [24:0]       rate;

  assign rdy = {pri_ready, reg_ready};
  // Streaming moves fixed 256-byte transactions with no delimiters
  assign len_sel[0]   = ctrl[`PSG_C_PKT_MODE] ? reg_len : `PSG_XFER_LEN;
  assign cnt_sel[0]   = ctrl[`PSG_C_PKT_MODE] ? reg_pkts : stream_total;
  assign pkt_flags[0] = ctrl[`PSG_C_PKT_MODE];
  assign len_sel[1]   = pri_len;
  assign cnt_sel[1]   = pri_pkts;
  assign pkt_flags[1] = 1'b1;
  assign tag_sel[0]   = ctrl[`PSG_C_MUX_EN] ? reg_tag : 8'h00;
  assign tag_sel[1]   = ctrl[`PSG_C_MUX_EN] ? {4'h0, pri_tag} & `PSG_PRI_TAG_MASK : 8'h00;
  assign pri_too_long = (pri_len > `PSG_PRI_MAX);
  assign period_bad   = (period < `PSG_PERIOD_MIN) || (period > `PSG_PERIOD_MAX);
  // A zero length or count would never end cleanly, so it blocks the start
  assign start_ok[0]  = HAS_REG && (len_sel[0] != 16'h0000) && (cnt_sel[0] != 32'h0);
  assign start_ok[1]  = HAS_PRI && !pri_too_long && (pri_len != 16'h0000) && (pri_pkts != 32'h0);
  assign use_arr      = !ctrl[`PSG_C_INC] || ctrl[`PSG_C_USER_SEL];
  assign user_wr      = wr && (addr == `PSG_A_USER);

  // Register write and read
  always_comb begin
    next_ctrl         = ctrl;
    next_reg_len      = reg_len;
    next_pri_len      = pri_len;
    next_reg_pkts     = reg_pkts;
    next_pri_pkts     = pri_pkts;
    next_stream_total = stream_total;
    next_reg_tag      = reg_tag;
    next_pri_tag      = pri_tag;
    next_period       = period;
    next_go           = 2'b00;
    next_rate_kick    = 1'b0;
    next_rdata        = 32'h0;
    if (wr) begin
      case (addr)
        `PSG_A_CTRL: begin
          next_ctrl = {wdata[`PSG_C_MUX_EN:`PSG_C_PKT_MODE], 2'b00};
          next_go   = wdata[`PSG_C_GO_PRI:`PSG_C_GO_REG];
        end
        `PSG_A_REG_LEN:  next_reg_len = wdata[15:0];
        `PSG_A_PRI_LEN:  next_pri_len = wdata[15:0];
        `PSG_A_REG_PKTS: next_reg_pkts = wdata;
        `PSG_A_PRI_PKTS: next_pri_pkts = wdata;
        `PSG_A_STREAM:   next_stream_total = wdata;
        `PSG_A_REG_TAG:  next_reg_tag = wdata[7:0];
        `PSG_A_PRI_TAG:  next_pri_tag = wdata[3:0];
        `PSG_A_PERIOD: begin
          next_period    = wdata[15:0];
          next_rate_kick = 1'b1;
        end
        default: ;
      endcase
    end
    if (rd) begin
      case (addr)
        `PSG_A_CTRL:     next_rdata = {23'h0, ctrl};
        `PSG_A_STATUS:   next_rdata = {26'h0, rate_busy, period_bad, !start_ok[0], pri_too_long, busy};
        `PSG_A_REG_LEN:  next_rdata = {16'h0, reg_len};
        `PSG_A_PRI_LEN:  next_rdata = {16'h0, pri_len};
        `PSG_A_REG_PKTS: next_rdata = reg_pkts;
        `PSG_A_PRI_PKTS: next_rdata = pri_pkts;
        `PSG_A_STREAM:   next_rdata = stream_total;
        `PSG_A_REG_TAG:  next_rdata = {24'h0, reg_tag};
        `PSG_A_PRI_TAG:  next_rdata = {28'h0, pri_tag};
        `PSG_A_PERIOD:   next_rdata = {16'h0, period};
        `PSG_A_RATE:     next_rdata = {7'h0, rate};
        default:         next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl         <= `PSG_RST_CTRL;
      reg_len      <= `PSG_RST_REG_LEN;
      pri_len      <= `PSG_RST_PRI_LEN;
      reg_pkts     <= `PSG_RST_REG_PKTS;
      pri_pkts     <= `PSG_RST_PRI_PKTS;
      stream_total <= `PSG_RST_STREAM;
      reg_tag      <= 8'h00;
      pri_tag      <= 4'h0;
      period       <= `PSG_RST_PERIOD;
      go           <= 2'b00;
      rate_kick    <= 1'b1;
      rdata        <= 32'h0;
    end else begin
      ctrl         <= next_ctrl;
      reg_len      <= next_reg_len;
      pri_len      <= next_pri_len;
      reg_pkts     <= next_reg_pkts;
      pri_pkts     <= next_pri_pkts;
      stream_total <= next_stream_total;
      reg_tag      <= next_reg_tag;
      pri_tag      <= next_pri_tag;
      period       <= next_period;
      go           <= next_go;
      rate_kick    <= next_rate_kick;
      rdata        <= next_rdata;
    end
  end

  // Lane rate = 20,000,000 / period in ps
  psg_rate_div #(
    .NUM_W (25),
    .DEN_W (16)
  ) u_rate (
    .clk   (clk),
    .rst   (rst),
    .start (rate_kick),
    .num   (`PSG_RATE_NUM),
    .den   (period),
    .quot  (rate),
    .busy  (rate_busy)
  );

  // One engine per data port, each with its own array and counter
  generate
    for (genvar g = 0; g < 2; g++) begin : gen_port
      psg_pkg::psg_state_e st, next_st;
      logic [15:0] pos, next_pos;
      logic [15:0] len, next_len;
      logic [31:0] left, next_left;
      logic [7:0]  inc, next_inc;
      logic        arr, next_arr;
      logic        sop_f, next_sop_f;
      logic        eop_f, next_eop_f;
      logic        err_f, next_err_f;
      logic        valid, next_valid;
      logic [7:0]  data, next_data;
      logic        sop, next_sop;
      logic        eop, next_eop;
      logic        err, next_err;
      logic [7:0]  chan, next_chan;
      wire         last, near_last;

      assign last      = (pos == 16'(len - 16'h0001));
      assign near_last = (16'(pos + 16'h0002) == len);

      // Loaded array only; writes while the port runs may corrupt the packet
      psg_payload_mem #(
        .ADDR_W (16)
      ) u_mem (
        .clk   (clk),
        .we    (user_wr && (wdata[`PSG_U_PORT] == 1'(g))),
        .waddr (wdata[`PSG_U_POS_HI:`PSG_U_POS_LO]),
        .wdata (wdata[7:0]),
        .raddr (pos),
        .rdata (mem_rd[g])
      );

      always_comb begin
        next_st    = st;
        next_pos   = pos;
        next_len   = len;
        next_left  = left;
        next_inc   = inc;
        next_arr   = arr;
        next_sop_f = sop_f;
        next_eop_f = eop_f;
        next_err_f = err_f;
        next_valid = valid;
        next_data  = data;
        next_sop   = sop;
        next_eop   = eop;
        next_err   = err;
        next_chan  = chan;
        case (st)
          psg_pkg::PSG_IDLE: begin
            // Starts while busy are dropped
            if (go[g] && start_ok[g]) begin
              next_st    = psg_pkg::PSG_LOAD;
              next_pos   = 16'h0000;
              next_inc   = 8'h00;
              next_len   = len_sel[g];
              next_left  = cnt_sel[g] - 32'h1;
              next_arr   = use_arr;
              next_sop_f = pkt_flags[g] && ctrl[`PSG_C_SOP_EN];
              next_eop_f = pkt_flags[g] && ctrl[`PSG_C_EOP_EN];
              next_err_f = pkt_flags[g] && ctrl[`PSG_C_EOP_EN] && ctrl[`PSG_C_ERR_EN];
              next_chan  = tag_sel[g];
            end
          end
          psg_pkg::PSG_LOAD: next_st = psg_pkg::PSG_FILL;
          psg_pkg::PSG_FILL: begin
            next_st    = psg_pkg::PSG_SEND;
            next_valid = 1'b1;
            next_data  = arr ? mem_rd[g] : inc;
            next_sop   = sop_f && (pos == 16'h0000);
            next_eop   = eop_f && last;
            next_err   = err_f && last;
          end
          psg_pkg::PSG_SEND: begin
            if (rdy[g]) begin
              next_sop = 1'b0;
              if (last) begin
                next_valid = 1'b0;
                next_eop   = 1'b0;
                next_err   = 1'b0;
                next_pos   = 16'h0000;
                next_inc   = 8'h00;
                if (left == 32'h0) begin
                  next_st = psg_pkg::PSG_IDLE;
                end else begin
                  next_left = left - 32'h1;
                  next_st   = psg_pkg::PSG_LOAD;
                end
              end else begin
                next_pos = pos + 16'h0001;
                next_inc = inc + 8'h01;
                if (arr) begin
                  next_valid = 1'b0;
                  next_st    = psg_pkg::PSG_LOAD;
                end else begin
                  // Array bytes get their markers in FILL, so none shows while valid is low
                  next_data = inc + 8'h01;
                  next_eop  = eop_f && near_last;
                  next_err  = err_f && near_last;
                end
              end
            end
          end
          default: next_st = psg_pkg::PSG_IDLE;
        endcase
      end

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          st    <= psg_pkg::PSG_IDLE;
          pos   <= 16'h0000;
          len   <= 16'h0000;
          left  <= 32'h0;
          inc   <= 8'h00;
          arr   <= 1'b0;
          sop_f <= 1'b0;
          eop_f <= 1'b0;
          err_f <= 1'b0;
          valid <= 1'b0;
          data  <= 8'h00;
          sop   <= 1'b0;
          eop   <= 1'b0;
          err   <= 1'b0;
          chan  <= 8'h00;
        end else begin
          st    <= next_st;
          pos   <= next_pos;
          len   <= next_len;
          left  <= next_left;
          inc   <= next_inc;
          arr   <= next_arr;
          sop_f <= next_sop_f;
          eop_f <= next_eop_f;
          err_f <= next_err_f;
          valid <= next_valid;
          data  <= next_data;
          sop   <= next_sop;
          eop   <= next_eop;
          err   <= next_err;
          chan  <= next_chan;
        end
      end

      assign busy[g]       = (st != psg_pkg::PSG_IDLE);
      assign port_valid[g] = valid;
      assign port_data[g]  = data;
      assign port_sop[g]   = sop;
      assign port_eop[g]   = eop;
      assign port_err[g]   = err;
      assign port_chan[g]  = chan;
    end
  endgenerate

  assign reg_valid = port_valid[0];
  assign reg_data  = port_data[0];
  assign reg_sop   = port_sop[0];
  assign reg_eop   = port_eop[0];
  assign reg_err   = port_err[0];
  assign reg_chan  = port_chan[0];
  assign pri_valid = port_valid[1];
  assign pri_data  = port_data[1];
  assign pri_sop   = port_sop[1];
  assign pri_eop   = port_eop[1];
  assign pri_err   = port_err[1];
  assign pri_chan  = port_chan[1][3:0];

endmodule

// >>> psg_map.svh
// Behaviour
// - Incrementing payload counter restarts at zero on every packet's first byte, both ports.
// - Incrementing payload counter wraps to zero after producing 0xFF.
// - Each data port has its own payload counter; ports never disturb each other.
// - Global pattern setting zero takes payload bytes from user-loaded content.
// - Per-packet source select: low leaves the global pattern setting in force, high gives loaded array.
// - Start-flag enable marks start-of-packet on the first byte; cleared in streaming.
// - End-flag enable marks end-of-packet on the last byte; cleared in streaming.
// - Fault-flag enable raises packet error together with end-of-packet; never in streaming.
// - Channel tag up to 0xFF regular, 0xF priority; zero when multiplexing disabled.
// - Exactly the requested number of bytes per packet, length one to 65535 regular, one to 256 priority.
// - Streaming sends configurable transactions, default twelve, of 256 bytes, no delimiters.
// - Priority packet count one to 2^32-1, default ten, only if priority port exists.
// - Regular packet count default ten, only with regular port present and packet mode.
// - Regular packets share one length, 1 to 65535, default 256.
// - Priority packets share one length, default ten bytes.
// - Lane rate in Mbps is 1000000 over clock period in ps, times twenty.
// - Bytes leave in ascending position order; position zero first, last position last.
`ifndef PSG_MAP_SVH
`define PSG_MAP_SVH

// Register indices
`define PSG_A_CTRL     4'h0
`define PSG_A_STATUS   4'h1
`define PSG_A_REG_LEN  4'h2
`define PSG_A_PRI_LEN  4'h3
`define PSG_A_REG_PKTS 4'h4
`define PSG_A_PRI_PKTS 4'h5
`define PSG_A_STREAM   4'h6
`define PSG_A_REG_TAG  4'h7
`define PSG_A_PRI_TAG  4'h8
`define PSG_A_PERIOD   4'h9
`define PSG_A_RATE     4'hA
`define PSG_A_USER     4'hB

// Control bits
`define PSG_C_GO_REG   0
`define PSG_C_GO_PRI   1
`define PSG_C_PKT_MODE 2
`define PSG_C_INC      3
`define PSG_C_SOP_EN   4
`define PSG_C_EOP_EN   5
`define PSG_C_ERR_EN   6
`define PSG_C_USER_SEL 7
`define PSG_C_MUX_EN   8

// User array write word
`define PSG_U_POS_LO   8
`define PSG_U_POS_HI   23
`define PSG_U_PORT     24

// Reset values
`define PSG_RST_CTRL     9'h03C
`define PSG_RST_REG_LEN  16'h0100
`define PSG_RST_PRI_LEN  16'h000A
`define PSG_RST_REG_PKTS 32'h0000000A
`define PSG_RST_PRI_PKTS 32'h0000000A
`define PSG_RST_STREAM   32'h0000000C
`define PSG_RST_PERIOD   16'h1900

// Limits
`define PSG_XFER_LEN     16'h0100
`define PSG_PRI_MAX      16'h0100
`define PSG_PERIOD_MIN   16'h1900
`define PSG_PERIOD_MAX   16'hC350
`define PSG_PRI_TAG_MASK 8'h0F
`define PSG_RATE_NUM     25'h1312D00

`endif

// >>> psg_pkg.sv
package psg_pkg;

  typedef enum logic [1:0] {
    PSG_IDLE = 2'b00,
    PSG_LOAD = 2'b01,
    PSG_FILL = 2'b10,
    PSG_SEND = 2'b11
  } psg_state_e;

  typedef logic [7:0] psg_byte_t;

endpackage

// >>> psg_payload_mem.sv
`timescale 1ns/10ps
module psg_payload_mem #(
  parameter int ADDR_W = 16
) (
  // Clock
  input  wire logic              clk,
  // Write side
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] waddr,
  input  psg_pkg::psg_byte_t     wdata,
  // Read side
  input  wire logic [ADDR_W-1:0] raddr,
  output psg_pkg::psg_byte_t     rdata
);

  psg_pkg::psg_byte_t mem [2**ADDR_W];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

// >>> psg_rate_div.sv
`timescale 1ns/10ps
module psg_rate_div #(
  parameter int NUM_W = 25,
  parameter int DEN_W = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Request
  input  wire logic             start,
  input  wire logic [NUM_W-1:0] num,
  input  wire logic [DEN_W-1:0] den,
  // Result
  output logic      [NUM_W-1:0] quot,
  output logic                  busy
);

  localparam int CNT_W = $clog2(NUM_W + 1);

  logic [DEN_W-1:0] rem;
  logic [DEN_W-1:0] next_rem;
  logic [NUM_W-1:0] next_quot;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             next_busy;
  logic [DEN_W:0]   trial;

  // Restoring division, one quotient bit per cycle; quot doubles as the dividend shifter
  always_comb begin
    next_rem  = rem;
    next_quot = quot;
    next_cnt  = cnt;
    next_busy = busy;
    trial     = {rem, quot[NUM_W-1]};
    if (start) begin
      next_rem  = '0;
      next_quot = num;
      next_cnt  = CNT_W'(NUM_W);
      next_busy = 1'b1;
    end else if (busy) begin
      if (trial >= {1'b0, den}) begin
        next_rem  = DEN_W'(trial - {1'b0, den});
        next_quot = {quot[NUM_W-2:0], 1'b1};
      end else begin
        next_rem  = trial[DEN_W-1:0];
        next_quot = {quot[NUM_W-2:0], 1'b0};
      end
      next_cnt  = cnt - 1'b1;
      next_busy = (cnt != CNT_W'(1));
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rem  <= '0;
      quot <= '0;
      cnt  <= '0;
      busy <= 1'b0;
    end else begin
      rem  <= next_rem;
      quot <= next_quot;
      cnt  <= next_cnt;
      busy <= next_busy;
    end
  end

endmodule

// >>> psg_gen_monitor.sv
`timescale 1ns/10ps
module psg_gen_monitor (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Register port
  input wire logic [3:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  // Regular port
  input wire logic        reg_ready,
  input wire logic        reg_valid,
  input wire logic [7:0]  reg_data,
  input wire logic        reg_sop,
  input wire logic        reg_eop,
  input wire logic        reg_err,
  input wire logic [7:0]  reg_chan,
  // Priority port
  input wire logic        pri_ready,
  input wire logic        pri_valid,
  input wire logic [7:0]  pri_data,
  input wire logic        pri_sop,
  input wire logic        pri_eop,
  input wire logic        pri_err,
  input wire logic [3:0]  pri_chan
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic        reg_acc;
  logic        pri_acc;
  logic [16:0] pri_cnt;
  logic [16:0] next_pri_cnt;
  assign reg_acc = reg_valid && reg_ready;
  assign pri_acc = pri_valid && pri_ready;
  // Bytes already taken in the current priority packet
  always_comb begin
    next_pri_cnt = pri_cnt;
    if (pri_acc) begin
      next_pri_cnt = pri_eop ? 17'h00000 : pri_cnt + 17'h00001;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pri_cnt <= 17'h00000;
    end else begin
      pri_cnt <= next_pri_cnt;
    end
  end
  reg_hold_a: assert property (reg_valid && !reg_ready |=> reg_valid && $stable(reg_data)
    && $stable({reg_sop, reg_eop, reg_err, reg_chan})) else $error("regular byte not held");
  pri_hold_a: assert property (pri_valid && !pri_ready |=> pri_valid && $stable(pri_data)
    && $stable({pri_sop, pri_eop, pri_err, pri_chan})) else $error("priority byte not held");
  reg_err_eop_a: assert property (reg_err |-> reg_eop && reg_valid)
    else $error("regular error without end");
  pri_err_eop_a: assert property (pri_err |-> pri_eop && pri_valid)
    else $error("priority error without end");
  reg_gap_a: assert property (reg_acc && reg_eop |=> !reg_valid [*2])
    else $error("regular packet gap missing");
  pri_gap_a: assert property (pri_acc && pri_eop |=> !pri_valid [*2])
    else $error("priority packet gap missing");
  reg_chan_held_a: assert property (reg_valid && $past(reg_valid) |-> $stable(reg_chan))
    else $error("regular tag changed");
  pri_chan_held_a: assert property (pri_valid && $past(pri_valid) |-> $stable(pri_chan))
    else $error("priority tag changed");
  pri_len_max_a: assert property (pri_valid |-> pri_cnt < 17'h00100)
    else $error("priority packet too long");
  cover property (reg_acc && reg_err);
  cover property (reg_valid && !reg_ready);
  cover property (pri_acc && pri_eop);
endmodule

// >>> psg_sink.sv
`timescale 1ns/10ps
module psg_sink (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Pace: low accepts every cycle, high one cycle in four
  input  wire logic       slow,
  // Data port
  input  wire logic       valid,
  input  wire logic [7:0] data,
  input  wire logic       sop,
  input  wire logic       eop,
  input  wire logic       err,
  input  wire logic [7:0] chan,
  output logic            ready
);
  logic [1:0]  ph;
  logic [18:0] rec[$];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ph <= 2'h0;
    end else begin
      ph <= ph + 2'h1;
      if (valid && ready) begin
        rec.push_back({chan, err, eop, sop, data});
      end
    end
  end
  assign ready = !rst && (!slow || ph == 2'h3);
endmodule

// >>> tb_psg_gen.sv
`timescale 1ns/10ps
module tb_psg_gen;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        reg_slow = 1'b0;
  logic [31:0] rdata;
  logic        reg_ready, reg_valid, reg_sop, reg_eop, reg_err;
  logic        pri_ready, pri_valid, pri_sop, pri_eop, pri_err;
  logic [7:0]  reg_data, reg_chan, pri_data;
  logic [3:0]  pri_chan;
  logic [18:0] got[$];
  int          errors = 0;
  int          n_tests = 0;
  always #4 clk = ~clk;
  psg_gen psg_gen_inst (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .reg_ready, .reg_valid, .reg_data,
    .reg_sop, .reg_eop, .reg_err, .reg_chan, .pri_ready, .pri_valid, .pri_data, .pri_sop, .pri_eop,
    .pri_err, .pri_chan);
  psg_sink psg_sink_inst (.clk, .rst, .slow(reg_slow), .valid(reg_valid), .data(reg_data),
    .sop(reg_sop), .eop(reg_eop), .err(reg_err), .chan(reg_chan), .ready(reg_ready));
  psg_sink psg_sink_pri_inst (.clk, .rst, .slow(reg_slow), .valid(pri_valid), .data(pri_data),
    .sop(pri_sop), .eop(pri_eop), .err(pri_err), .chan({4'h0, pri_chan}), .ready(pri_ready));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, exp, what);
  endtask
  // Polls status until both ports and the rate divider are idle
  task automatic wait_idle();
    repeat (4) @(posedge clk);
    for (int i = 0; i < 20000; i++) begin
      @(posedge clk);
      rd <= 1'b1;
      addr <= 4'h1;
      @(posedge clk);
      rd <= 1'b0;
      #1 if (rdata[1:0] === 2'b00 && rdata[5] === 1'b0) return;
    end
    errors++;
    $display("MISMATCH %0t wait timeout", $time);
    complete_run();
  endtask
  function automatic logic [7:0] ua(input int p);
    return 8'(p * 29 + 3);
  endfunction
  // Compares everything the sink took against the expected packets
  task automatic verify(input bit pri, input int npk, input int len, input logic [7:0] ch,
                        input bit fl, input bit er, input bit arr);
    logic [18:0] e;
    int          p;
    got = pri ? psg_sink_pri_inst.rec : psg_sink_inst.rec;
    check(got.size(), npk * len, "byte count");
    for (int i = 0; i < got.size() && i < npk * len; i++) begin
      p = i % len;
      e[7:0] = arr ? ua(p) : p[7:0];
      e[8] = fl && p == 0;
      e[9] = fl && p == len - 1;
      e[10] = er && e[9];
      e[18:11] = ch;
      check({13'h0, got[i]}, {13'h0, e}, "byte");
    end
    if (pri) begin
      psg_sink_pri_inst.rec.delete();
    end else begin
      psg_sink_inst.rec.delete();
    end
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_chk(4'h2, 32'h00000100, "reg len");
    rd_chk(4'h3, 32'h0000000A, "pri len");
    rd_chk(4'h4, 32'h0000000A, "reg count");
    rd_chk(4'h5, 32'h0000000A, "pri count");
    rd_chk(4'h6, 32'h0000000C, "stream total");
    rd_chk(4'h0, 32'h0000003C, "ctrl");
    rd_chk(4'hF, 32'h00000000, "unmapped");
    wait_idle();
    rd_chk(4'hA, 32'h00000C35, "rate");
    wr_reg(4'h9, 32'h000018FF);
    wait_idle();
    rd_chk(4'h1, 32'h00000010, "period flag");
    wr_reg(4'h9, 32'h0000C350);
    wait_idle();
    rd_chk(4'hA, 32'h00000190, "rate slow");
    $display("Test defaults done");
    // Both ports at once, both sinks stalled, long packets wrap the counter
    @(posedge clk) reg_slow <= 1'b1;
    wr_reg(4'h2, 32'h0000012C);
    wr_reg(4'h4, 32'h00000002);
    wr_reg(4'h7, 32'h0000005A);
    wr_reg(4'h3, 32'h00000005);
    wr_reg(4'h5, 32'h00000003);
    wr_reg(4'h8, 32'h00000037);
    wr_reg(4'h0, 32'h0000017F);
    wait_idle();
    verify(1'b0, 2, 300, 8'h5A, 1'b1, 1'b1, 1'b0);
    verify(1'b1, 3, 5, 8'h07, 1'b1, 1'b1, 1'b0);
    $display("Test dual port done");
    // Over-long priority packets never start; 256 does
    wr_reg(4'h3, 32'h00000101);
    rd_chk(4'h1, 32'h00000004, "pri cfg flag");
    wr_reg(4'h0, 32'h0000007E);
    wait_idle();
    check(psg_sink_pri_inst.rec.size(), 32'h0, "refused run");
    @(posedge clk) reg_slow <= 1'b0;
    wr_reg(4'h3, 32'h00000100);
    wr_reg(4'h5, 32'h00000001);
    wr_reg(4'h2, 32'h00000001);
    wr_reg(4'h4, 32'h00000003);
    wr_reg(4'h0, 32'h0000003F);
    wait_idle();
    verify(1'b0, 3, 1, 8'h00, 1'b1, 1'b0, 1'b0);
    verify(1'b1, 1, 256, 8'h00, 1'b1, 1'b0, 1'b0);
    $display("Test limits done");
    // Loaded payload, by global setting and by per-packet select
    @(posedge clk) reg_slow <= 1'b1;
    for (int p = 0; p < 5; p++) begin
      wr_reg(4'hB, {8'h00, 16'(p), ua(p)});
      wr_reg(4'hB, {8'h01, 16'(p), ua(p)});
    end
    wr_reg(4'h2, 32'h00000005);
    wr_reg(4'h4, 32'h00000001);
    wr_reg(4'h3, 32'h00000005);
    wr_reg(4'h0, 32'h00000077);
    wait_idle();
    verify(1'b0, 1, 5, 8'h00, 1'b1, 1'b1, 1'b1);
    verify(1'b1, 1, 5, 8'h00, 1'b1, 1'b1, 1'b1);
    wr_reg(4'h0, 32'h000000BF);
    wait_idle();
    verify(1'b0, 1, 5, 8'h00, 1'b1, 1'b0, 1'b1);
    verify(1'b1, 1, 5, 8'h00, 1'b1, 1'b0, 1'b1);
    $display("Test loaded payload done");
    // Streaming ignores the error enable and carries no markers
    wr_reg(4'h6, 32'h00000002);
    wr_reg(4'h0, 32'h00000049);
    wait_idle();
    verify(1'b0, 2, 256, 8'h00, 1'b0, 1'b0, 1'b0);
    $display("Test streaming done");
    complete_run();
  end
endmodule
bind psg_gen psg_gen_monitor psg_gen_monitor_inst (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .reg_ready,
  .reg_valid, .reg_data, .reg_sop, .reg_eop, .reg_err, .reg_chan, .pri_ready, .pri_valid, .pri_data,
  .pri_sop, .pri_eop, .pri_err, .pri_chan);
